/* verilog/riv_pkg.sv */
/*
 * Shared constants and types for the reference input validity status block.
 * Assumes a single 10 MHz clock domain and a simple strobe register port.
 */
package riv_pkg;

	localparam int          NUM_INPUTS   = 14;
	localparam int          LOW_COUNT    = 8;
	localparam int          HIGH_COUNT   = 6;
	localparam int          ADDR_W       = 8;
	localparam int          DATA_W       = 8;

	// Register offsets
	localparam logic [7:0]  OFS_VALID_LO = 8'h00;
	localparam logic [7:0]  OFS_VALID_HI = 8'h01;
	localparam logic [7:0]  OFS_IRQ_STS  = 8'h02;
	localparam logic [7:0]  OFS_IRQ_STS2 = 8'h03;
	localparam logic [7:0]  OFS_IRQ_MSK  = 8'h04;
	localparam logic [7:0]  OFS_IRQ_MSK2 = 8'h05;

	localparam logic [7:0]  RST_VALID    = 8'h00;
	localparam logic [7:0]  RST_MASK     = 8'h00;
	localparam logic [7:0]  UNMAPPED_VAL = 8'h00;

	// Alarm set per input
	typedef struct packed {
		logic soft_oob;
		logic hard_oob;
		logic no_activity;
		logic phase_lock;
	} riv_alarm_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} riv_bus_req_t;

endpackage : riv_pkg

/* verilog/riv_sync2.sv */
/*
 * Two-flop synchroniser for a bus of asynchronous levels.
 * Assumes inputs come from outside the ref_clk_i domain.
 */
`timescale 1ns/10ps
module riv_sync2 #(
	parameter int W = 1
) (
	input  wire logic         ref_clk_i, // Clock
	input  wire logic         reset_i,   // Sync reset, active high
	input  wire logic [W-1:0] async_i,   // Asynchronous levels
	output logic      [W-1:0] sync_o     // Synchronised levels
);
	logic [W-1:0] meta;

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			meta   <= '0;
			sync_o <= '0;
		end else begin
			meta   <= async_i;
			sync_o <= meta;
		end
	end
endmodule : riv_sync2

/* verilog/riv_valid_cell.sv */
/*
 * Validity decision for one reference input.
 * Assumes alarm flags are already in the ref_clk_i domain.
 */
`timescale 1ns/10ps
module riv_valid_cell (
	input  wire riv_pkg::riv_alarm_t alarm_i, // Alarm flags of one input
	output logic                     valid_o  // High when input is valid
);
	// Soft frequency alarm alone keeps the input valid
	assign valid_o = ~(alarm_i.hard_oob | alarm_i.no_activity | alarm_i.phase_lock);
endmodule : riv_valid_cell

/* verilog/riv_top.sv */
/*
 * Reference input validity status registers with change interrupts.
 * Assumes alarm flags arrive asynchronously and a single-cycle strobe master.
 */
`timescale 1ns/10ps
module riv_top (
	input  wire logic                                    ref_clk_i, // 10 MHz clock
	input  wire logic                                    reset_i,   // Sync reset, active high
	input  wire riv_pkg::riv_alarm_t [riv_pkg::NUM_INPUTS-1:0] alarm_i, // Per-input alarms
	input  wire logic [riv_pkg::ADDR_W-1:0]              addr_i,    // Register address
	input  wire logic [riv_pkg::DATA_W-1:0]              wdata_i,   // Write data
	input  wire logic                                    wr_i,      // Write strobe
	input  wire logic                                    rd_i,      // Read strobe
	output logic      [riv_pkg::DATA_W-1:0]              rdata_o,   // Read data, next cycle
	output logic      [riv_pkg::NUM_INPUTS-1:0]          valid_o,   // Registered validity
	output logic                                         irq_o      // Level interrupt
);
	localparam int N = riv_pkg::NUM_INPUTS;

	riv_pkg::riv_alarm_t [N-1:0] alarm_s;
	logic                [N-1:0] valid_comb;
	logic                [N-1:0] valid_q;
	logic                [N-1:0] valid_d1;
	logic                [N-1:0] irq_sts;
	logic                [N-1:0] irq_msk;
	logic                [N-1:0] change_ev;
	logic                [N-1:0] clr_bits;
	logic                [N-1:0] next_sts;
	logic                [N-1:0] next_msk;
	logic                        primed;
	logic [riv_pkg::DATA_W-1:0]  next_rdata;
	logic [riv_pkg::DATA_W-1:0]  reg_lo;
	logic [riv_pkg::DATA_W-1:0]  reg_hi;
	logic                        sel_lo;
	logic                        sel_hi;
	logic                        sel_sts;
	logic                        sel_sts2;
	logic                        sel_msk;
	logic                        sel_msk2;

	riv_sync2 #(
		.W($bits(alarm_i))
	) u_sync (
		.ref_clk_i(ref_clk_i),
		.reset_i  (reset_i),
		.async_i  (alarm_i),
		.sync_o   (alarm_s)
	);

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_cell
			riv_valid_cell u_cell (
				.alarm_i(alarm_s[g]),
				.valid_o(valid_comb[g])
			);
		end
	endgenerate

	// Address decode
	assign sel_lo   = (addr_i == riv_pkg::OFS_VALID_LO);
	assign sel_hi   = (addr_i == riv_pkg::OFS_VALID_HI);
	assign sel_sts  = (addr_i == riv_pkg::OFS_IRQ_STS);
	assign sel_sts2 = (addr_i == riv_pkg::OFS_IRQ_STS2);
	assign sel_msk  = (addr_i == riv_pkg::OFS_IRQ_MSK);
	assign sel_msk2 = (addr_i == riv_pkg::OFS_IRQ_MSK2);

	assign reg_lo = valid_q[riv_pkg::LOW_COUNT-1:0];
	assign reg_hi = {2'h0, valid_q[N-1:riv_pkg::LOW_COUNT]};

	assign next_rdata = !rd_i    ? riv_pkg::UNMAPPED_VAL :
	                    sel_lo   ? reg_lo :
	                    sel_hi   ? reg_hi :
	                    sel_sts  ? irq_sts[7:0] :
	                    sel_sts2 ? {2'h0, irq_sts[N-1:8]} :
	                    sel_msk  ? irq_msk[7:0] :
	                    sel_msk2 ? {2'h0, irq_msk[N-1:8]} :
	                    riv_pkg::UNMAPPED_VAL;

	// Validity change events, write-one-to-clear with set priority
	assign change_ev = primed ? (valid_q ^ valid_d1) : '0;
	assign clr_bits  = !wr_i    ? '0 :
	                   sel_sts  ? {6'h00, wdata_i} :
	                   sel_sts2 ? {wdata_i[5:0], 8'h00} :
	                   '0;
	assign next_sts  = (irq_sts & ~clr_bits) | change_ev;
	assign next_msk  = !wr_i    ? irq_msk :
	                   sel_msk  ? {irq_msk[N-1:8], wdata_i} :
	                   sel_msk2 ? {wdata_i[5:0], irq_msk[7:0]} :
	                   irq_msk;

	// Live tracking; validity registers take no write
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			valid_q  <= '0;
			valid_d1 <= '0;
			primed   <= 1'b0;
		end else begin
			valid_q  <= valid_comb;
			valid_d1 <= valid_q;
			primed   <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			irq_sts <= '0;
			irq_msk <= '0;
			rdata_o <= riv_pkg::RST_VALID;
			valid_o <= '0;
			irq_o   <= 1'b0;
		end else begin
			irq_sts <= next_sts;
			irq_msk <= next_msk;
			rdata_o <= next_rdata;
			valid_o <= valid_comb;
			irq_o   <= |(next_sts & next_msk);
		end
	end

	// Validity decision
	property p_hard_invalid;
		@(posedge ref_clk_i) disable iff (reset_i)
		alarm_s[0].hard_oob |=> !valid_q[0];
	endproperty
	a_hard_invalid: assert property (p_hard_invalid)
		else $error("hard alarm did not invalidate input 1");

	property p_soft_only;
		@(posedge ref_clk_i) disable iff (reset_i)
		(alarm_s[9] == 4'h8) |=> valid_q[9];
	endproperty
	a_soft_only: assert property (p_soft_only)
		else $error("soft-only alarm invalidated input 10");

	property p_soft_hard;
		@(posedge ref_clk_i) disable iff (reset_i)
		(alarm_s[7].soft_oob && alarm_s[7].hard_oob) |=> !valid_q[7];
	endproperty
	a_soft_hard: assert property (p_soft_hard)
		else $error("soft alarm masked a hard alarm on input 8");

	property p_noact_invalid;
		@(posedge ref_clk_i) disable iff (reset_i)
		alarm_s[4].no_activity |=> !valid_q[4];
	endproperty
	a_noact_invalid: assert property (p_noact_invalid)
		else $error("activity alarm did not invalidate input 5");

	property p_lock_invalid;
		@(posedge ref_clk_i) disable iff (reset_i)
		alarm_s[11].phase_lock |=> !valid_q[11];
	endproperty
	a_lock_invalid: assert property (p_lock_invalid)
		else $error("phase lock alarm did not invalidate input 12");

	property p_polarity;
		@(posedge ref_clk_i) disable iff (reset_i)
		(alarm_s[13] == 4'h0) |=> valid_o[13];
	endproperty
	a_polarity: assert property (p_polarity)
		else $error("alarm-free input 14 not valid");

	property p_valid_track;
		@(posedge ref_clk_i) disable iff (reset_i)
		!$past(reset_i) |-> valid_q == $past(valid_comb);
	endproperty
	a_valid_track: assert property (p_valid_track)
		else $error("validity did not follow alarms");

	property p_valid_o_match;
		@(posedge ref_clk_i) disable iff (reset_i)
		valid_o == valid_q;
	endproperty
	a_valid_o_match: assert property (p_valid_o_match)
		else $error("validity output differs from register");

	// Register reads
	property p_lo_read;
		@(posedge ref_clk_i) disable iff (reset_i)
		(rd_i && sel_lo) |=> rdata_o == $past(valid_q[7:0]);
	endproperty
	a_lo_read: assert property (p_lo_read)
		else $error("low register read mismatch");

	property p_hi_read;
		@(posedge ref_clk_i) disable iff (reset_i)
		(rd_i && sel_hi) |=> rdata_o[7:6] == 2'h0 && rdata_o[5:0] == $past(valid_q[13:8]);
	endproperty
	a_hi_read: assert property (p_hi_read)
		else $error("high register read mismatch");

	property p_unmapped_zero;
		@(posedge ref_clk_i) disable iff (reset_i)
		(rd_i && (addr_i > riv_pkg::OFS_IRQ_MSK2)) |=> rdata_o == 8'h00;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero)
		else $error("unmapped read not zero");

	property p_rdata_idle;
		@(posedge ref_clk_i) disable iff (reset_i)
		!rd_i |=> rdata_o == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data not zero outside a read");

	property p_sts_read;
		@(posedge ref_clk_i) disable iff (reset_i)
		(rd_i && sel_sts) |=> rdata_o == $past(irq_sts[7:0]);
	endproperty
	a_sts_read: assert property (p_sts_read)
		else $error("status read mismatch");

	property p_msk_read;
		@(posedge ref_clk_i) disable iff (reset_i)
		(rd_i && sel_msk2) |=> rdata_o == {2'h0, $past(irq_msk[13:8])};
	endproperty
	a_msk_read: assert property (p_msk_read)
		else $error("high mask read mismatch");

	// Register writes
	property p_wr_ignored;
		@(posedge ref_clk_i) disable iff (reset_i)
		(wr_i && (sel_lo || sel_hi) && $stable(valid_comb)) |=> valid_q == $past(valid_comb);
	endproperty
	a_wr_ignored: assert property (p_wr_ignored)
		else $error("write disturbed validity");

	property p_msk_write;
		@(posedge ref_clk_i) disable iff (reset_i)
		(wr_i && sel_msk) |=> irq_msk[7:0] == $past(wdata_i);
	endproperty
	a_msk_write: assert property (p_msk_write)
		else $error("low mask write lost");

	property p_msk_write2;
		@(posedge ref_clk_i) disable iff (reset_i)
		(wr_i && sel_msk2) |=> irq_msk[13:8] == $past(wdata_i[5:0]);
	endproperty
	a_msk_write2: assert property (p_msk_write2)
		else $error("high mask write lost");

	// Change events and interrupt
	property p_irq_set;
		@(posedge ref_clk_i) disable iff (reset_i)
		(primed && (valid_q[3] != valid_d1[3])) |=> irq_sts[3];
	endproperty
	a_irq_set: assert property (p_irq_set)
		else $error("validity change not latched");

	property p_sts_sticky;
		@(posedge ref_clk_i) disable iff (reset_i)
		(irq_sts[2] && !(wr_i && sel_sts && wdata_i[2])) |=> irq_sts[2];
	endproperty
	a_sts_sticky: assert property (p_sts_sticky)
		else $error("status bit dropped without clear");

	property p_sts_clear;
		@(posedge ref_clk_i) disable iff (reset_i)
		(wr_i && sel_sts && wdata_i[0] && !change_ev[0]) |=> !irq_sts[0];
	endproperty
	a_sts_clear: assert property (p_sts_clear)
		else $error("status bit not cleared by write");

	property p_set_wins;
		@(posedge ref_clk_i) disable iff (reset_i)
		(wr_i && sel_sts2 && wdata_i[1] && change_ev[9]) |=> irq_sts[9];
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("clear beat a same-cycle event");

	property p_irq_out;
		@(posedge ref_clk_i) disable iff (reset_i)
		irq_o == |(irq_sts & irq_msk);
	endproperty
	a_irq_out: assert property (p_irq_out)
		else $error("interrupt output mismatch");

	property p_irq_masked;
		@(posedge ref_clk_i) disable iff (reset_i)
		(irq_msk == '0 && !wr_i) |=> !irq_o;
	endproperty
	a_irq_masked: assert property (p_irq_masked)
		else $error("interrupt raised while fully masked");

endmodule : riv_top

/* bench/tb_riv_top.sv */
/*
 * Self-checking bench for the validity status block: random alarms, register reads,
 * ignored writes, unmapped read, interrupt mask and clear.
 * Assumes riv_pkg offsets and an 8-cycle settle window after each alarm change.
 */
`timescale 1ns/10ps
module tb_riv_top;
	logic                                          ref_clk_i;
	logic                                          reset_i;
	logic                                          wr_i;
	logic                                          rd_i;
	riv_pkg::riv_alarm_t [riv_pkg::NUM_INPUTS-1:0] alarm_i;
	logic [7:0]                                    addr_i;
	logic [7:0]                                    wdata_i;
	logic [7:0]                                    rdata_o;
	logic [7:0]                                    d;
	logic [13:0]                                   valid_o;
	logic [13:0]                                   mv;
	logic [13:0]                                   pv;
	logic [13:0]                                   sts;
	logic [13:0]                                   msk;
	logic [63:0]                                   r;
	logic                                          irq_o;
	int                                            err_total;
	int                                            total_checks;
	int                                            i;

	riv_top i_riv_top (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .alarm_i(alarm_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .valid_o(valid_o), .irq_o(irq_o));

	initial begin
		ref_clk_i = 1'b0;
		forever #50 ref_clk_i = ~ref_clk_i;
	end

	task end_sim;
		if (err_total == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : end_sim

	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [7:0] w);
		@(posedge ref_clk_i);
		addr_i  <= a;
		wdata_i <= w;
		wr_i    <= 1'b1;
		@(posedge ref_clk_i);
		wr_i    <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, output logic [7:0] q);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge ref_clk_i);
		rd_i   <= 1'b0;
		#1 q = rdata_o;
	endtask : rd

	// Model: valid unless hard, no-activity or phase-lock alarm is up
	task settle;
		repeat (8) @(posedge ref_clk_i);
		#1;
		for (int j = 0; j < 14; j++) mv[j] = ~|alarm_i[j][2:0];
		sts = sts | (pv ^ mv);
		pv  = mv;
		chk("valid_o", {2'h0, mv}, {2'h0, valid_o});
		chk("irq_o", {15'h0, |(sts & msk)}, {15'h0, irq_o});
	endtask : settle

	task regs;
		rd(8'h00, d);
		chk("valid_low", {8'h00, mv[7:0]}, {8'h00, d});
		rd(8'h01, d);
		chk("valid_high", {10'h000, mv[13:8]}, {8'h00, d});
		rd(8'h02, d);
		chk("irq_sts_low", {8'h00, sts[7:0]}, {8'h00, d});
		rd(8'h03, d);
		chk("irq_sts_high", {10'h000, sts[13:8]}, {8'h00, d});
		rd(8'h04, d);
		chk("irq_msk_low", {8'h00, msk[7:0]}, {8'h00, d});
		rd(8'h05, d);
		chk("irq_msk_high", {10'h000, msk[13:8]}, {8'h00, d});
		rd(8'h3C, d);
		chk("unmapped", 16'h0000, {8'h00, d});
	endtask : regs

	initial begin
		reset_i = 1'b1; wr_i = 1'b0; rd_i = 1'b0; addr_i = 8'h00; wdata_i = 8'h00;
		alarm_i = '0; err_total = 0; total_checks = 0; pv = '0; sts = '0; msk = '0;
		repeat (12) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		void'($urandom(17));
		settle;
		regs;
		for (i = 0; i < 24; i++) begin
			if (i == 8) begin
				wr(8'h04, 8'hFF);
				wr(8'h05, 8'h3F);
				msk = 14'h3FFF;
			end
			if (i == 16) begin
				wr(8'h05, 8'h00);
				msk = 14'h00FF;
			end
			r = {$urandom, $urandom};
			// Every third pattern carries soft alarms only
			@(posedge ref_clk_i);
			alarm_i <= (i % 3 == 0) ? r[55:0] & {14{4'h8}} : r[55:0];
			wr(8'h00, r[63:56]);
			wr(8'h01, r[63:56]);
			settle;
			regs;
			if (i % 4 == 3) begin
				wr(8'h02, 8'hFF);
				wr(8'h03, 8'h3F);
				sts = '0;
				repeat (2) @(posedge ref_clk_i);
				#1 chk("irq_cleared", 16'h0000, {15'h0, irq_o});
			end
		end
		end_sim;
	end

	initial begin
		repeat (5000) @(posedge ref_clk_i);
		err_total++;
		end_sim;
	end
endmodule : tb_riv_top
